// file: rtl/memctl_defs.vh
`ifndef MEMCTL_DEFS_VH
`define MEMCTL_DEFS_VH

// ****************************************************************
// Register map of the controller (word indices on the bus)
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_RDATA 4'h3
`define REG_STATUS 4'h4

// Control register fields.
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_SRAM 2
`define CTRL_RESET 3
`define CTRL_UB_N 4
`define CTRL_LB_N 5

// Status register fields.
`define STAT_BUSY 0
`define STAT_IN_RESET 1
`define STAT_WAKE 2
`define STAT_DONE 3

// ****************************************************************
// Flash commands and identifier-space offsets
// ****************************************************************
`define CMD_READ_ARRAY 16'h00FF
`define CMD_READ_ID 16'h0090
`define ID_MAKER 22'h000000
`define ID_PART 22'h000001
`define ID_LOCK_LOW 16'h0002
`define ID_OTP_LOCK 22'h000080
`define ID_OTP_FIRST 22'h000081
`define ID_OTP_LAST 22'h000088

// ****************************************************************
// Timing (ns figures and derived cycle counts at 25 MHz)
// ****************************************************************
`define CLK_NS 40
`define ACCESS_NS 70
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define WE_PULSE_NS 50
`define WE_PULSE_CYC ((`WE_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_LOW_NS 100
`define RESET_LOW_CYC ((`RESET_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define PHQV_NS 150
`define PHQV_CYC ((`PHQV_NS + `CLK_NS - 1) / `CLK_NS)
`define PHWL_NS 150
`define PHWL_CYC ((`PHWL_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: rtl/cycle_timer.v
`timescale 1ns/1ns
`include "memctl_defs.vh"

// ****************************************************************
// Down counter that flags when a loaded count has elapsed
// ****************************************************************
module cycle_timer (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire [7:0] count_i,
    output wire expired_o
);

    reg [7:0] remain;

    // The count loads and then runs down to zero, where it rests.
    always @(posedge clk_i) begin
        if (rst_i) begin
            remain <= 8'h00;
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != 8'h00) begin
            remain <= remain - 8'h01;
        end
    end

    assign expired_o = (remain == 8'h00) && !load_i;

endmodule

// file: rtl/memctl_host.v
`timescale 1ns/1ns
`include "memctl_defs.vh"

// Contract
// - Flash read drives reset high, enable low, output enable low, write enable high.
// - SRAM read drives select one low, select two high, output enable low.
// - After reset release wait before reading and, longer, before writing; the code waits 150 ns (PHQV_NS, PHWL_NS) for both.
// - Flash write only with enable and write enable low, output enable high.
// - SRAM write with select one, write enable low, output enable high.
// - Write FFh before array reads when not in read-array mode.
// - Host must not rely on reserved identifier addresses.
// - Never let flash and SRAM drive the shared bus together.
module memctl_host (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    output reg [21:0] mem_addr_o,
    input wire [15:0] mem_data_i,
    output reg [15:0] mem_data_o,
    output reg mem_data_oe_n_o,
    output reg flash_reset_n_o,
    output reg flash_ce_n_o,
    output reg flash_oe_n_o,
    output reg flash_we_n_o,
    output reg sram_select_one_n_o,
    output reg sram_select_two_o,
    output reg sram_oe_n_o,
    output reg sram_we_n_o,
    output reg sram_upper_byte_n_o,
    output reg sram_lower_byte_n_o,
    output reg read_id_mode_o
);

    // ****************************************************************
    // States of the bus sequencer
    // ****************************************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_RESET_LOW = 3'd1;
    localparam ST_WAKE = 3'd2;
    localparam ST_SETUP = 3'd3;
    localparam ST_STROBE = 3'd4;
    localparam ST_RELEASE = 3'd5;
    localparam ST_TURN = 3'd6;

    reg [2:0] state;
    reg [21:0] addr_reg;
    reg [15:0] wdata_reg;
    reg [15:0] rdata_reg;
    reg op_write;
    reg op_sram;
    reg ub_n;
    reg lb_n;
    reg busy;
    reg done;
    reg in_reset;
    reg read_ready;
    reg write_ready;
    reg id_mode;
    reg [15:0] data_s1;
    reg [15:0] data_s2;
    reg [15:0] data_s3;
    reg [7:0] since_release;

    wire timer_expired;
    reg timer_load;
    reg [7:0] timer_count;

    wire bus_req;
    wire go_req;
    wire reset_req;
    reg [15:0] data_stable;
    reg after_reset;

    // ****************************************************************
    // Register access helpers
    // ****************************************************************

    // Byte lanes merge a write into a stored word.
    function [31:0] merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Classifies a written flash command into the identifier-mode flag.
    function next_id_flag;
        input current;
        input [15:0] cmd;
        begin
            if (cmd[7:0] == `CMD_READ_ID) begin
                next_id_flag = 1'b1;
            end else if (cmd[7:0] == `CMD_READ_ARRAY) begin
                next_id_flag = 1'b0;
            end else begin
                next_id_flag = current;
            end
        end
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign go_req = bus_req && wb_we_i && (wb_adr_i == `REG_CTRL) && wb_sel_i[0]
        && wb_dat_i[`CTRL_GO] && !busy;
    assign reset_req = go_req && wb_dat_i[`CTRL_RESET];
    // Merged words and cycle counts are cut to their targets' widths on purpose.
    wire [31:0] addr_merged = merge({10'h000, addr_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] wdata_merged = merge({16'h0000, wdata_reg}, wb_dat_i, wb_sel_i);
    wire [31:0] we_cyc = `WE_PULSE_CYC;
    wire [31:0] rd_cyc = `ACCESS_CYC + 32'h3;
    wire [31:0] rst_cyc = `RESET_LOW_CYC;

    // The read bus passes three flops; data counts once the last two agree.
    always @(posedge clk_i) begin
        if (rst_i) begin
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
            data_s3 <= 16'h0000;
            data_stable <= 16'h0000;
        end else begin
            data_s1 <= mem_data_i;
            data_s2 <= data_s1;
            data_s3 <= data_s2;
            if (data_s2 == data_s3) begin
                data_stable <= data_s3;
            end
        end
    end

    cycle_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .count_i(timer_count),
        .expired_o(timer_expired)
    );

    // ****************************************************************
    // Wishbone slave: single-cycle ack, unmapped reads return zero
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            addr_reg <= 22'h000000;
            wdata_reg <= 16'h0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && wb_we_i) begin
                if (wb_adr_i == `REG_ADDR && !busy) begin
                    addr_reg <= addr_merged[21:0];
                end else if (wb_adr_i == `REG_WDATA && !busy) begin
                    wdata_reg <= wdata_merged[15:0];
                end
            end
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i == `REG_ADDR) begin
                    wb_dat_o <= {10'h000, addr_reg};
                end else if (wb_adr_i == `REG_WDATA) begin
                    wb_dat_o <= {16'h0000, wdata_reg};
                end else if (wb_adr_i == `REG_RDATA) begin
                    wb_dat_o <= {16'h0000, rdata_reg};
                end else if (wb_adr_i == `REG_STATUS) begin
                    wb_dat_o <= {26'h0000000, id_mode, write_ready, done, read_ready,
                                 in_reset, busy};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // Counts cycles since reset release; it saturates so both delays stay met.
    always @(posedge clk_i) begin
        if (rst_i || in_reset) begin
            since_release <= 8'h00;
        end else if (since_release != 8'hFF) begin
            since_release <= since_release + 8'h01;
        end
    end

    // Read and write permission after wake-up are separate delays.
    always @(posedge clk_i) begin
        if (rst_i) begin
            read_ready <= 1'b0;
            write_ready <= 1'b0;
        end else begin
            read_ready <= !in_reset && (since_release >= `PHQV_CYC);
            write_ready <= !in_reset && (since_release >= `PHWL_CYC);
        end
    end

    // ****************************************************************
    // Bus sequencer
    // ****************************************************************

    // Timer loads are combinational so the count starts on the entry edge.
    always @* begin
        timer_load = 1'b0;
        timer_count = 8'h00;
        if (state == ST_SETUP) begin
            timer_load = 1'b1;
            timer_count = op_write ? we_cyc[7:0] : rd_cyc[7:0];
        end else if ((state == ST_IDLE && reset_req) || after_reset) begin
            timer_load = 1'b1;
            timer_count = rst_cyc[7:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_RESET_LOW;
            busy <= 1'b1;
            done <= 1'b0;
            in_reset <= 1'b1;
            id_mode <= 1'b0;
            op_write <= 1'b0;
            op_sram <= 1'b0;
            ub_n <= 1'b1;
            lb_n <= 1'b1;
            rdata_reg <= 16'h0000;
            after_reset <= 1'b1;
            flash_reset_n_o <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            sram_select_one_n_o <= 1'b1;
            sram_select_two_o <= 1'b0;
            sram_oe_n_o <= 1'b1;
            sram_we_n_o <= 1'b1;
            sram_upper_byte_n_o <= 1'b1;
            sram_lower_byte_n_o <= 1'b1;
            mem_addr_o <= 22'h000000;
            mem_data_o <= 16'h0000;
            mem_data_oe_n_o <= 1'b1;
            read_id_mode_o <= 1'b0;
        end else begin
            read_id_mode_o <= id_mode;
            after_reset <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (go_req && wb_dat_i[`CTRL_RESET]) begin
                        // Reset also aborts any program or erase inside the flash.
                        flash_reset_n_o <= 1'b0;
                        in_reset <= 1'b1;
                        busy <= 1'b1;
                        done <= 1'b0;
                        state <= ST_RESET_LOW;
                    end else if (go_req && (wb_dat_i[`CTRL_SRAM] || (wb_dat_i[`CTRL_WRITE]
                            ? write_ready : read_ready))) begin
                        op_write <= wb_dat_i[`CTRL_WRITE];
                        op_sram <= wb_dat_i[`CTRL_SRAM];
                        ub_n <= wb_dat_i[`CTRL_UB_N];
                        lb_n <= wb_dat_i[`CTRL_LB_N];
                        busy <= 1'b1;
                        done <= 1'b0;
                        state <= ST_SETUP;
                    end
                end
                ST_RESET_LOW: begin
                    if (timer_expired) begin
                        // Rising reset returns the flash to read-array mode.
                        flash_reset_n_o <= 1'b1;
                        in_reset <= 1'b0;
                        id_mode <= 1'b0;
                        state <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (read_ready) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_SETUP: begin
                    // Address and write data are driven on the same edge as the strobes fall.
                    mem_addr_o <= addr_reg;
                    mem_data_o <= wdata_reg;
                    mem_data_oe_n_o <= !op_write;
                    if (op_sram) begin
                        // Flash stays deselected so only one die can drive.
                        flash_ce_n_o <= 1'b1;
                        sram_select_one_n_o <= 1'b0;
                        sram_select_two_o <= 1'b1;
                        sram_oe_n_o <= op_write;
                        sram_we_n_o <= !op_write;
                        sram_upper_byte_n_o <= ub_n;
                        sram_lower_byte_n_o <= lb_n;
                    end else begin
                        sram_select_one_n_o <= 1'b1;
                        sram_oe_n_o <= 1'b1;
                        flash_ce_n_o <= 1'b0;
                        flash_oe_n_o <= op_write;
                        flash_we_n_o <= !op_write;
                    end
                    state <= ST_STROBE;
                end
                ST_STROBE: begin
                    if (timer_expired) begin
                        if (!op_write) begin
                            rdata_reg <= data_stable;
                        end
                        // Write enable rises before enable so data latches on it.
                        flash_we_n_o <= 1'b1;
                        sram_we_n_o <= 1'b1;
                        flash_oe_n_o <= 1'b1;
                        sram_oe_n_o <= 1'b1;
                        if (op_write && !op_sram) begin
                            id_mode <= next_id_flag(id_mode, wdata_reg);
                        end
                        state <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    // Deselect both dies, then release the data bus a cycle later.
                    flash_ce_n_o <= 1'b1;
                    sram_select_one_n_o <= 1'b1;
                    sram_select_two_o <= 1'b0;
                    sram_upper_byte_n_o <= 1'b1;
                    sram_lower_byte_n_o <= 1'b1;
                    state <= ST_TURN;
                end
                ST_TURN: begin
                    mem_data_oe_n_o <= 1'b1;
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// file: testbench/memctl_host_monitor.sv
`timescale 1ns/1ns

// ****************************************************************
// Pin-level checks of the memory controller
// ****************************************************************
module memctl_host_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire [15:0] mem_data_o,
    input wire mem_data_oe_n_o,
    input wire flash_reset_n_o,
    input wire flash_ce_n_o,
    input wire flash_oe_n_o,
    input wire flash_we_n_o,
    input wire sram_select_one_n_o,
    input wire sram_select_two_o,
    input wire sram_oe_n_o,
    input wire sram_we_n_o,
    input wire read_id_mode_o
);
    // Each die is asked to drive the shared bus under these levels.
    wire f_rd = flash_reset_n_o && !flash_ce_n_o && !flash_oe_n_o;
    wire s_rd = !sram_select_one_n_o && sram_select_two_o && !sram_oe_n_o;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_flash_write: assert property (
        !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_reset_n_o && !mem_data_oe_n_o)
        else $error("Flash write strobe with wrong control levels.");
    a_sram_write: assert property (
        !sram_we_n_o |-> !sram_select_one_n_o && sram_select_two_o && sram_oe_n_o
        && !mem_data_oe_n_o) else $error("SRAM write strobe with wrong control levels.");
    a_flash_read: assert property (
        !flash_oe_n_o |-> f_rd && flash_we_n_o && !s_rd)
        else $error("Flash read with wrong control levels.");
    a_sram_read: assert property (
        !sram_oe_n_o |-> s_rd && sram_we_n_o && (flash_ce_n_o || flash_oe_n_o))
        else $error("SRAM read with wrong control levels.");
    a_no_bus_fight: assert property (
        !(f_rd && s_rd) && (mem_data_oe_n_o || !(f_rd || s_rd)))
        else $error("Two parties drive the memory data bus.");
    a_reset_idle: assert property (
        !flash_reset_n_o |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o)
        else $error("Flash strobed while held in reset.");
    a_wake_wait: assert property (
        $rose(flash_reset_n_o) |-> flash_ce_n_o [*4])
        else $error("Flash selected before the wake-up delay.");
    a_id_enter: assert property (
        $rose(flash_we_n_o) && !flash_ce_n_o && mem_data_o[7:0] == 8'h90
        |-> ##[1:4] read_id_mode_o) else $error("Identifier mode flag not set.");
    a_id_leave: assert property (
        $rose(flash_we_n_o) && !flash_ce_n_o && mem_data_o[7:0] == 8'hFF
        |-> ##[1:4] !read_id_mode_o) else $error("Identifier mode flag not cleared.");
    a_ack_pulse: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus answer is not a single pulse on the next edge.");

    // Main scenarios that the bench should reach.
    cover property ($rose(flash_we_n_o) && !flash_ce_n_o);
    cover property (s_rd);
    cover property ($rose(read_id_mode_o));
endmodule

bind memctl_host memctl_host_monitor u_mon (.*);

// file: testbench/stacked_mem_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Behavioural flash plus SRAM on one asynchronous bus
// ****************************************************************
module stacked_mem_model #(
    parameter [15:0] MAKER_CODE = 16'h5A3C, // Arbitrary value.
    parameter [15:0] PART_CODE = 16'h7E11 // Arbitrary value.
) (
    input wire [21:0] addr_i,
    input wire [15:0] data_i,
    output wire [15:0] data_o,
    input wire flash_reset_n_i,
    input wire flash_ce_n_i,
    input wire flash_oe_n_i,
    input wire flash_we_n_i,
    input wire sram_select_one_n_i,
    input wire sram_select_two_i,
    input wire sram_oe_n_i,
    input wire sram_we_n_i,
    input wire sram_upper_byte_n_i,
    input wire sram_lower_byte_n_i
);
    reg id_mode = 1'b0;
    reg [15:0] last = 16'h0000;
    reg [15:0] id_word;
    reg [15:0] ram [0:255];
    wire f_drv = flash_reset_n_i && !flash_ce_n_i && !flash_oe_n_i && flash_we_n_i;
    wire s_drv = !sram_select_one_n_i && sram_select_two_i && !sram_oe_n_i;
    wire [15:0] f_val = id_mode ? id_word : (addr_i[15:0] ^ 16'h5A00);

    // A released bus shows the inverse of the last word, so stale data never passes.
    assign data_o = f_drv ? f_val : (s_drv ? ram[addr_i[7:0]] : ~last);

    // Remember what was last driven.
    always @* begin
        if (f_drv) last = f_val;
        else if (s_drv) last = ram[addr_i[7:0]];
    end

    // Identifier space; every block reads back locked since reset.
    always @* begin
        if (addr_i == 22'h0) id_word = MAKER_CODE;
        else if (addr_i == 22'h1) id_word = PART_CODE;
        else if (addr_i == 22'h80) id_word = 16'hFFFE;
        else if (addr_i >= 22'h81 && addr_i <= 22'h88) id_word = {12'hC00, addr_i[3:0]};
        else if (addr_i[11:0] == 12'h002) id_word = 16'h0001;
        else id_word = 16'h0000;
    end

    // Commands latch on whichever strobe rises first; the array is never touched.
    always @(posedge flash_we_n_i or posedge flash_ce_n_i) begin
        if (flash_reset_n_i === 1'b1 && (flash_ce_n_i === 1'b0 || flash_we_n_i === 1'b0)) begin
            if (data_i[7:0] == 8'hFF) id_mode <= 1'b0;
            else if (data_i[7:0] == 8'h90) id_mode <= 1'b1;
        end
    end

    // Reset returns the flash to array reads; no program or erase runs here to cut short.
    always @(negedge flash_reset_n_i) id_mode <= 1'b0;

    // SRAM writes take the enabled byte lanes at the end of the strobe.
    always @(posedge sram_we_n_i) begin
        if (!sram_select_one_n_i && sram_select_two_i) begin
            if (!sram_upper_byte_n_i) ram[addr_i[7:0]][15:8] <= data_i[15:8];
            if (!sram_lower_byte_n_i) ram[addr_i[7:0]][7:0] <= data_i[7:0];
        end
    end
endmodule

// file: testbench/tb_stacked_flash_sram_bus_modes.sv
`timescale 1ns/1ns

// ****************************************************************
// Bench for the stacked memory controller
// ****************************************************************
module tb_stacked_flash_sram_bus_modes;
    localparam [15:0] MAKER = 16'h5A3C; // Arbitrary value.
    localparam [15:0] PART = 16'h7E11; // Arbitrary value.
    reg clk_i;
    reg rst_i;
    reg [3:0] wb_adr_i;
    reg [31:0] wb_dat_i;
    reg wb_we_i;
    reg [3:0] wb_sel_i;
    reg wb_cyc_i;
    reg wb_stb_i;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [21:0] mem_addr_o;
    wire [15:0] mem_data_i, mem_data_o;
    wire mem_data_oe_n_o, flash_reset_n_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o;
    wire sram_select_one_n_o, sram_select_two_o, sram_oe_n_o, sram_we_n_o;
    wire sram_upper_byte_n_o, sram_lower_byte_n_o, read_id_mode_o;
    integer n_mismatch;
    integer checks_done;
    reg [15:0] r;

    memctl_host u_dut (.*);

    stacked_mem_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_mem (
        .addr_i(mem_addr_o), .data_i(mem_data_o), .data_o(mem_data_i),
        .flash_reset_n_i(flash_reset_n_o), .flash_ce_n_i(flash_ce_n_o),
        .flash_oe_n_i(flash_oe_n_o), .flash_we_n_i(flash_we_n_o),
        .sram_select_one_n_i(sram_select_one_n_o), .sram_select_two_i(sram_select_two_o),
        .sram_oe_n_i(sram_oe_n_o), .sram_we_n_i(sram_we_n_o),
        .sram_upper_byte_n_i(sram_upper_byte_n_o), .sram_lower_byte_n_i(sram_lower_byte_n_o));

    // Free-running 25 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task check(input string what, input [31:0] exp, input [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // One classic cycle; the request stands until ack is seen at an edge.
    task wb_cycle(input [3:0] a, input [31:0] d, input w, output [31:0] q);
        integer n;
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_we_i <= w;
            wb_sel_i <= 4'hF;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 50) begin
                @(posedge clk_i);
                n = n + 1;
            end
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            if (n >= 50) check("bus answer", 32'h1, 32'h0);
        end
    endtask

    task wait_idle;
        integer i;
        reg [31:0] q;
        begin
            i = 0;
            q = 32'h1;
            while (q[0] !== 1'b0 && i < 100) begin
                wb_cycle(4'h4, 32'h0, 1'b0, q);
                i = i + 1;
            end
            check("busy flag", 32'h0, {31'h0, q[0]});
        end
    endtask

    // Load address and data, start the transfer, wait and fetch the result.
    task mem_op(input [7:0] ctl, input [21:0] a, input [15:0] d, output [15:0] q);
        reg [31:0] x;
        begin
            wb_cycle(4'h1, {10'h000, a}, 1'b1, x);
            wb_cycle(4'h2, {16'h0000, d}, 1'b1, x);
            wb_cycle(4'h0, {24'h000000, ctl}, 1'b1, x);
            wait_idle;
            wb_cycle(4'h3, 32'h0, 1'b0, x);
            q = x[15:0];
        end
    endtask

    task rd_check(input [21:0] a, input [15:0] e);
        begin
            mem_op(8'h01, a, 16'h0000, r);
            check("flash word", {16'h0000, e}, {16'h0000, r});
        end
    endtask

    task test_wake;
        reg [31:0] q;
        begin
            wait_idle;
            wb_cycle(4'h4, 32'h0, 1'b0, q);
            check("reset status", 32'h0, {31'h0, q[1]});
            check("read ready", 32'h1, {31'h0, q[2]});
            rd_check(22'h5, 16'h5A05);
            $display("test_wake finished");
        end
    endtask

    task test_sram;
        begin
            mem_op(8'h07, 22'h3, 16'hBEEF, r);
            mem_op(8'h05, 22'h3, 16'h0000, r);
            check("sram word", 32'h0000BEEF, {16'h0000, r});
            mem_op(8'h27, 22'h3, 16'h1234, r);
            mem_op(8'h05, 22'h3, 16'h0000, r);
            check("sram lanes", 32'h000012EF, {16'h0000, r});
            rd_check(22'h3, 16'h5A03);
            $display("test_sram finished");
        end
    endtask

    task test_id;
        begin
            mem_op(8'h03, 22'h1, 16'h0090, r);
            check("mode flag", 32'h1, {31'h0, read_id_mode_o});
            rd_check(22'h0, MAKER);
            rd_check(22'h1, PART);
            rd_check(22'h80, 16'hFFFE);
            rd_check(22'h81, 16'hC001);
            rd_check(22'h88, 16'hC008);
            rd_check(22'h3002, 16'h0001);
            mem_op(8'h03, 22'h0, 16'h00AA, r);
            rd_check(22'h1, PART);
            mem_op(8'h03, 22'h1, 16'h00FF, r);
            check("mode flag", 32'h0, {31'h0, read_id_mode_o});
            rd_check(22'h1, 16'h5A01);
            $display("test_id finished");
        end
    endtask

    task test_reset;
        reg [31:0] q;
        begin
            mem_op(8'h03, 22'h0, 16'h0090, r);
            wb_cycle(4'h0, 32'h9, 1'b1, q);
            wait_idle;
            check("mode flag", 32'h0, {31'h0, read_id_mode_o});
            rd_check(22'h2, 16'h5A02);
            mem_op(8'h03, 22'h0, 16'h0090, r);
            rd_check(22'h8002, 16'h0001);
            mem_op(8'h03, 22'h0, 16'h00FF, r);
            $display("test_reset finished");
        end
    endtask

    task test_regs;
        reg [31:0] q;
        begin
            wb_cycle(4'h1, 32'hFFFFFFFF, 1'b1, q);
            wb_cycle(4'h1, 32'h0, 1'b0, q);
            check("address register", 32'h003FFFFF, q);
            wb_cycle(4'h9, 32'h1234, 1'b1, q);
            wb_cycle(4'h9, 32'h0, 1'b0, q);
            check("unmapped read", 32'h0, q);
            $display("test_regs finished");
        end
    endtask

    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
            if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Cuts a hang short well beyond the expected run of about six hundred cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch = n_mismatch + 1;
        final_report;
    end

    // Main sequence.
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst_i = 1'b1;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        test_wake;
        test_sram;
        test_id;
        test_reset;
        test_regs;
        final_report;
    end
endmodule
